// ---- logic/ccs_ctrl.sv ----
// Purpose: control word, serial framing and operating mode sequencing
// Assumes: sclk idles between frames; conv_busy is on clk
// Notes:   pin path passes the clk synchroniser, about 3 clk of lag
`timescale 1ns/1ps
`default_nettype none
module ccs_ctrl #(
   parameter int CNT_W = 16
) (
   // clocks and reset
   input  wire logic clk,
   input  wire logic nrst,
   // serial link
   input  wire logic sclk,
   input  wire logic cs_n,
   input  wire logic din,
   output logic      dout_rdy_o,
   output logic      dout_rdy_oe,
   // converter side
   input  wire logic conv_busy,
   input  wire logic data_ready,
   input  wire logic rdy_to_pin_en,
   output logic      ref_enable,
   output logic      internal_reference_level_select,
   output logic      filter_reset,
   output logic      conv_single,
   output logic      conv_standby,
   output logic      conv_power_down,
   // error flags
   output logic      serial_write_error_flag,
   output logic      serial_read_error_flag,
   output logic      serial_clock_count_error_flag
);
   ////////////////////////////////////////////////////////////////////
   // link domain
   logic [15:0] ctrl_reg;
   logic        sif_rst;
   logic [4:0]  cnt_reg, cnt_next;
   logic [22:0] sh_reg, sh_next;
   logic [15:0] rd_reg, rd_next;
   logic [15:0] wdata_reg, wdata_next;
   logic        rd_act_reg, rd_act_next;
   logic        over_reg, over_next;
   logic        wr_tgl_reg, wr_tgl_next;
   logic        werr_tgl_reg, werr_tgl_next;
   logic        rerr_tgl_reg, rerr_tgl_next;
   logic [23:0] full;
   logic        csb;

   // 4-wire: select high clears the frame at once
   assign csb     = ctrl_reg[ccs_pkg::BIT_CHIP_SELECT_PIN_ENABLE];
   assign sif_rst = ~nrst | (cs_n & csb);
   assign full    = {sh_reg, din};

   always_comb begin
      cnt_next      = cnt_reg + 5'h01;
      sh_next       = full[22:0];
      rd_next       = {rd_reg[14:0], 1'b0};
      wdata_next    = wdata_reg;
      rd_act_next   = rd_act_reg;
      over_next     = over_reg;
      wr_tgl_next   = wr_tgl_reg;
      werr_tgl_next = werr_tgl_reg;
      rerr_tgl_next = rerr_tgl_reg;
      if (cnt_reg == ccs_pkg::CMD_LAST) begin
         rd_act_next = full[ccs_pkg::CMD_READ_BIT];
         if (full[ccs_pkg::CMD_READ_BIT]) begin
            if (full[5:0] == ccs_pkg::CTRL_ADDR) begin
               // control word only changes on writes, stable here
               rd_next = ctrl_reg;
            end else begin
               rerr_tgl_next = ~rerr_tgl_reg;
            end
         end
      end
      if (cnt_reg == ccs_pkg::FRAME_LAST) begin
         if (!full[16 + ccs_pkg::CMD_READ_BIT]) begin
            if (full[21:16] == ccs_pkg::CTRL_ADDR) begin
               wdata_next  = full[15:0];
               wr_tgl_next = ~wr_tgl_reg;
            end else begin
               werr_tgl_next = ~werr_tgl_reg;
            end
         end
         if (csb) begin
            cnt_next = ccs_pkg::FRAME_DONE;
         end else begin
            cnt_next    = 5'h00;
            rd_act_next = 1'b0;
         end
      end
      if (cnt_reg == ccs_pkg::FRAME_DONE) begin
         if (csb) begin
            // extra clocks in 4-wire mark a count error
            cnt_next  = ccs_pkg::FRAME_DONE;
            over_next = 1'b1;
         end else begin
            // 4-wire left before select rose: this edge opens a frame
            cnt_next    = 5'h01;
            rd_act_next = 1'b0;
         end
      end
   end

   always_ff @(posedge sclk or posedge sif_rst) begin
      if (sif_rst) begin
         cnt_reg    <= 5'h00;
         sh_reg     <= 23'h000000;
         rd_reg     <= 16'h0000;
         rd_act_reg <= 1'b0;
         over_reg   <= 1'b0;
      end else begin
         cnt_reg    <= cnt_next;
         sh_reg     <= sh_next;
         rd_reg     <= rd_next;
         rd_act_reg <= rd_act_next;
         over_reg   <= over_next;
      end
   end

   // toggles survive select so no event is faked
   always_ff @(posedge sclk or negedge nrst) begin
      if (!nrst) begin
         wdata_reg    <= 16'h0000;
         wr_tgl_reg   <= 1'b0;
         werr_tgl_reg <= 1'b0;
         rerr_tgl_reg <= 1'b0;
      end else begin
         wdata_reg    <= wdata_next;
         wr_tgl_reg   <= wr_tgl_next;
         werr_tgl_reg <= werr_tgl_next;
         rerr_tgl_reg <= rerr_tgl_next;
      end
   end

   // data leaves on the falling edge
   logic out_bit_reg, out_bit_next;
   logic phase_reg, phase_next;
   logic bad;

   // rising-edge state: no falling edge follows the last rising one
   assign bad = over_reg || (cnt_reg != 5'h00 &&
                             cnt_reg != ccs_pkg::FRAME_DONE);

   always_comb begin
      out_bit_next = rd_reg[15];
      phase_next   = rd_act_reg && (cnt_reg > ccs_pkg::CMD_LAST);
   end

   always_ff @(negedge sclk or posedge sif_rst) begin
      if (sif_rst) begin
         out_bit_reg <= 1'b0;
         phase_reg   <= 1'b0;
      end else begin
         out_bit_reg <= out_bit_next;
         phase_reg   <= phase_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // crossing into clk: three stages, accept when stages 2 and 3 agree
   // [0] cs_n [1] phase [2] bit [3] bad [4] wr [5] werr [6] rerr
   logic [6:0] s1_reg, s2_reg, s3_reg, f_reg, f_next;
   logic [6:0] agree;

   assign agree = ~(s2_reg ^ s3_reg);

   always_comb begin
      f_next = (agree & s3_reg) | (~agree & f_reg);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s1_reg <= 7'h01;
         s2_reg <= 7'h01;
         s3_reg <= 7'h01;
         f_reg  <= 7'h01;
      end else begin
         // 3-wire: read phase ends at the last rising edge, not falling
         s1_reg <= {rerr_tgl_reg, werr_tgl_reg, wr_tgl_reg, bad,
                    out_bit_reg, phase_reg & rd_act_reg, cs_n};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         f_reg  <= f_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // control word and error flags
   logic [15:0] ctrl_next;
   logic [3:0]  wmode;
   logic        wr_ev, werr_ev, rerr_ev, cs_rise;
   logic        werr_reg, werr_next, rerr_reg, rerr_next;
   logic        cnterr_reg, cnterr_next;

   assign wr_ev   = f_next[4] ^ f_reg[4];
   assign werr_ev = f_next[5] ^ f_reg[5];
   assign rerr_ev = f_next[6] ^ f_reg[6];
   assign cs_rise = f_next[0] & ~f_reg[0];
   assign wmode   = wdata_reg[ccs_pkg::MODE_LSB +: 4];

   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ev) begin
         ctrl_next = wdata_reg & ccs_pkg::CTRL_WR_MASK;
         if (wmode == ccs_pkg::M_PDOWN &&
             ctrl_reg[ccs_pkg::MODE_LSB +: 4] != ccs_pkg::M_STBY) begin
            ctrl_next[ccs_pkg::MODE_LSB +: 4] = ccs_pkg::M_RUN;
         end
      end
      // flags carry no meaning outside 4-wire; leaving 4-wire clears them even when a set arrives in the same cycle
      werr_next   = csb & (werr_reg | werr_ev);
      rerr_next   = csb & (rerr_reg | rerr_ev);
      cnterr_next = csb & (cnterr_reg | (cs_rise & f_reg[3]));
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctrl_reg   <= ccs_pkg::CTRL_RESET;
         werr_reg   <= 1'b0;
         rerr_reg   <= 1'b0;
         cnterr_reg <= 1'b0;
      end else begin
         ctrl_reg   <= ctrl_next;
         werr_reg   <= werr_next;
         rerr_reg   <= rerr_next;
         cnterr_reg <= cnterr_next;
      end
   end

   assign serial_write_error_flag       = werr_reg;
   assign serial_read_error_flag        = rerr_reg;
   assign serial_clock_count_error_flag = cnterr_reg;

   ////////////////////////////////////////////////////////////////////
   // shared data/ready pin
   logic       pin_reg, pin_next, oe_reg, oe_next;
   logic [3:0] dly_reg, dly_next;

   always_comb begin
      dly_next = (dly_reg != 4'h0) ? dly_reg - 4'h1 : 4'h0;
      pin_next = ~(data_ready & rdy_to_pin_en);
      if (f_reg[1] && !f_next[1] && ctrl_reg[ccs_pkg::BIT_OUT_DLY]) begin
         dly_next = ccs_pkg::OUT_DLY_CYC;
      end
      if (f_next[1]) begin
         pin_next = f_next[2];
      end else if (dly_next != 4'h0) begin
         pin_next = pin_reg;
      end
      oe_next = ~f_next[0];
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pin_reg <= 1'b1;
         oe_reg  <= 1'b0;
         dly_reg <= 4'h0;
      end else begin
         pin_reg <= pin_next;
         oe_reg  <= oe_next;
         dly_reg <= dly_next;
      end
   end

   assign dout_rdy_o  = pin_reg;
   assign dout_rdy_oe = oe_reg;

   ////////////////////////////////////////////////////////////////////
   // operating mode and duty cycling
   ccs_pkg::ccs_state_t st_reg, st_next;
   logic [CNT_W-1:0]   act_reg, act_next;
   logic [CNT_W+3:0]   sb_reg, sb_next;
   logic [3:0]         mode;
   logic [CNT_W+3:0]   act_w;
   logic               ref_en_next, ref_lv_next, fr_next;
   logic               sgl_next, stby_next, pd_next;
   logic               ref_en_reg, ref_lv_reg, fr_reg;
   logic               sgl_reg, stby_reg, pd_reg;

   assign mode  = ctrl_reg[ccs_pkg::MODE_LSB +: 4];
   assign act_w = {4'h0, act_reg};

   always_comb begin
      st_next  = st_reg;
      act_next = act_reg;
      sb_next  = sb_reg;
      case (mode)
         ccs_pkg::M_RUN:    st_next = ccs_pkg::S_RUN;
         ccs_pkg::M_SINGLE: st_next = ccs_pkg::S_SINGLE;
         ccs_pkg::M_STBY:   st_next = ccs_pkg::S_STBY;
         ccs_pkg::M_PDOWN:  st_next = ccs_pkg::S_PDOWN;
         ccs_pkg::M_IDLE:   st_next = ccs_pkg::S_IDLE;
         ccs_pkg::M_DUTY: begin
            case (st_reg)
               ccs_pkg::S_DUTY_A: begin
                  // active time is whatever the conversions took
                  if (conv_busy) begin
                     act_next = act_reg + 1'b1;
                  end else if (act_reg != '0) begin
                     st_next = ccs_pkg::S_DUTY_SB;
                     sb_next = ctrl_reg[ccs_pkg::BIT_DUTY] ?
                               (act_w << 4) - act_w :
                               (act_w << 2) - act_w;
                  end
               end
               ccs_pkg::S_DUTY_SB: begin
                  sb_next = sb_reg - 1'b1;
                  if (sb_reg <= 1) begin
                     st_next  = ccs_pkg::S_DUTY_A;
                     act_next = '0;
                  end
               end
               default: begin
                  st_next  = ccs_pkg::S_DUTY_A;
                  act_next = '0;
               end
            endcase
         end
         default: st_next = ccs_pkg::S_RUN;
      endcase
      ref_en_next = ctrl_reg[ccs_pkg::BIT_REF_EN];
      ref_lv_next = ctrl_reg[ccs_pkg::BIT_REF_EN] &
                    ctrl_reg[ccs_pkg::BIT_REF_LEVEL];
      fr_next     = st_next == ccs_pkg::S_IDLE;
      sgl_next    = st_next == ccs_pkg::S_SINGLE;
      stby_next   = st_next == ccs_pkg::S_STBY ||
                    st_next == ccs_pkg::S_DUTY_SB;
      pd_next     = st_next == ccs_pkg::S_PDOWN;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_reg     <= ccs_pkg::S_RUN;
         act_reg    <= '0;
         sb_reg     <= '0;
         ref_en_reg <= 1'b0;
         ref_lv_reg <= 1'b0;
         fr_reg     <= 1'b0;
         sgl_reg    <= 1'b0;
         stby_reg   <= 1'b0;
         pd_reg     <= 1'b0;
      end else begin
         st_reg     <= st_next;
         act_reg    <= act_next;
         sb_reg     <= sb_next;
         ref_en_reg <= ref_en_next;
         ref_lv_reg <= ref_lv_next;
         fr_reg     <= fr_next;
         sgl_reg    <= sgl_next;
         stby_reg   <= stby_next;
         pd_reg     <= pd_next;
      end
   end

   assign ref_enable                      = ref_en_reg;
   assign internal_reference_level_select = ref_lv_reg;
   assign filter_reset                    = fr_reg;
   assign conv_single                     = sgl_reg;
   assign conv_standby                    = stby_reg;
   assign conv_power_down                 = pd_reg;
endmodule
`default_nettype wire

// ---- logic/ccs_pkg.sv ----
// Purpose: constants for the converter control and serial mode block
// Assumes: one 16-bit control word reached over the serial link
// Notes:   Behaviour list below
//
// Behaviour
// - select bit 0: 3-wire link, interface resets after last rising sclk
// - 3-wire read: pin turns from data to ready at last rising sclk
// - output disable delay bit postpones the data to ready switch
// - pin floats whenever select is high, also in 3-wire mode
// - select bit 1: 4-wire link, interface resets on select rising
// - 4-wire read: pin turns from data to ready at select rising
// - write, read and clock count error flags only valid in 4-wire
// - reference enable bit, reset 0: reference off; 1: on
// - enabled reference output level chosen by level select bit
// - ratio bit 0: active 1/4; 1: active 1/16 of the time
// - ratio only used while mode holds duty cycling code 1001
// - active time is summed conversion time; standby a multiple of it
// - mode field bits 5:2, read/write, resets to 0
// - 0 run, 1 single, 2 standby, 3 power-down only from standby
// - mode 0100 holds filter and modulator in reset, nothing else
package ccs_pkg;
   localparam logic [15:0] CTRL_RESET    = 16'h0000;
   localparam logic [15:0] CTRL_WR_MASK  = 16'h0F7C;
   localparam int          BIT_REF_LEVEL = 11;
   localparam int          BIT_OUT_DLY   = 10;
   localparam int          BIT_CHIP_SELECT_PIN_ENABLE    = 9;
   localparam int          BIT_REF_EN    = 8;
   localparam int          BIT_RESERVED  = 7;
   localparam int          BIT_DUTY      = 6;
   localparam int          MODE_LSB      = 2;
   localparam logic [5:0]  CTRL_ADDR     = 6'h01;
   localparam int          CMD_READ_BIT  = 6;
   localparam logic [4:0]  CMD_LAST      = 5'h07;
   localparam logic [4:0]  FRAME_LAST    = 5'h17;
   localparam logic [4:0]  FRAME_DONE    = 5'h18;
   localparam logic [3:0]  M_RUN         = 4'h0;
   localparam logic [3:0]  M_SINGLE      = 4'h1;
   localparam logic [3:0]  M_STBY        = 4'h2;
   localparam logic [3:0]  M_PDOWN       = 4'h3;
   localparam logic [3:0]  M_IDLE        = 4'h4;
   localparam logic [3:0]  M_DUTY        = 4'h9;
   localparam int          OUT_DLY_NS    = 20;
   localparam int          CLK_MHZ       = 250;
   localparam logic [3:0]  OUT_DLY_CYC   =
      4'((OUT_DLY_NS * CLK_MHZ + 999) / 1000);

   typedef enum logic [6:0] {
      S_RUN     = 7'h01,
      S_SINGLE  = 7'h02,
      S_STBY    = 7'h04,
      S_PDOWN   = 7'h08,
      S_IDLE    = 7'h10,
      S_DUTY_A  = 7'h20,
      S_DUTY_SB = 7'h40
   } ccs_state_t;
endpackage

// ---- verification/ccs_ctrl_bench.sv ----
// Purpose: self-checking bench of the control block
// Assumes: host model drives the link at 64 ns per sclk
// Notes:   10 clk gap after each frame keeps write-to-read spacing
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
failures++; $display("Error at %0t got %h exp %h", $time, a, b); end end
module ccs_ctrl_bench;
   logic        clk, nrst, busy, drdy, four, dout, oe, refe, lvl;
   logic        fres, sgl, stby, pdn, werr, rerr, cerr;
   wire  logic  sclk, cs_n, din;
   logic [15:0] rd;
   int          failures, samples_checked, cyc, n;
   logic [3:0]  wm [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h0, 4'hF, 4'h3};
   logic [3:0]  em [7] = '{4'h4, 4'h2, 4'h1, 4'h8, 4'h0, 4'h0, 4'h0};
   ccs_ctrl dut (.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
      .din(din), .dout_rdy_o(dout), .dout_rdy_oe(oe), .conv_busy(busy),
      .data_ready(drdy), .rdy_to_pin_en(1'b1), .ref_enable(refe),
      .internal_reference_level_select(lvl), .filter_reset(fres),
      .conv_single(sgl), .conv_standby(stby), .conv_power_down(pdn),
      .serial_write_error_flag(werr), .serial_read_error_flag(rerr),
      .serial_clock_count_error_flag(cerr));
   ccs_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic xf(input logic [7:0] c, input logic [15:0] d,
                     input int k);
      host.xfer(c, d, k, four, rd);
      tick(10);
   endtask
   task automatic wr(input logic [15:0] d);
      xf({2'b00, ccs_pkg::CTRL_ADDR}, d, 24);
   endtask
   task automatic rdc(input logic [15:0] e);
      xf({2'b01, ccs_pkg::CTRL_ADDR}, 16'h0000, 24);
      `CHK(rd, e)
   endtask
   task automatic give_verdict();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      {nrst, busy, drdy, four} = 4'h0;
      failures = 0;
      samples_checked = 0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      tick(2);
      `CHK({refe, lvl, dout, oe}, 4'b0010)
      rdc(16'h0000);
      `CHK(oe, 1'b1)
      $display("test reset done");
      wr(16'h0900);
      `CHK({refe, lvl}, 2'b11)
      wr(16'h0800);
      `CHK({refe, lvl}, 2'b00)
      wr(16'hF4C0);
      rdc(16'h0440);
      $display("test reference done");
      // last data bit is 0 and ready shows 1, so the switch is visible
      host.xfer(8'h41, 16'h0000, 24, 1'b0, rd);
      tick(7);
      `CHK(dout, 1'b0)
      tick(8);
      `CHK(dout, 1'b1)
      wr(16'h0040);
      host.xfer(8'h41, 16'h0000, 24, 1'b0, rd);
      tick(7);
      `CHK(dout, 1'b1)
      @(posedge clk) drdy <= 1'b1;
      tick(6);
      `CHK(dout, 1'b0)
      @(posedge clk) drdy <= 1'b0;
      $display("test pin switch done");
      for (int i = 0; i < 7; i++) begin
         wr({10'h000, wm[i], 2'b00});
         `CHK({fres, sgl, stby, pdn}, em[i])
      end
      rdc(16'h0000);
      $display("test modes done");
      for (int r = 0; r < 2; r++) begin
         wr({9'h000, r[0], ccs_pkg::M_DUTY, 2'b00});
         @(posedge clk) busy <= 1'b1;
         repeat (8) @(posedge clk);
         busy <= 1'b0;
         n = 0;
         for (int k = 0; k < 40 && stby !== 1'b1; k++) tick(1);
         while (stby === 1'b1 && n < 400) begin
            n++;
            tick(1);
         end
         `CHK((n + 4) / 8, (r == 1) ? 15 : 3)
      end
      wr(16'h0040);
      @(posedge clk) busy <= 1'b1;
      repeat (8) @(posedge clk);
      busy <= 1'b0;
      tick(12);
      `CHK(stby, 1'b0)
      $display("test duty done");
      wr(16'h0200);
      four = 1'b1;
      rdc(16'h0200);
      `CHK(oe, 1'b0)
      `CHK(cerr, 1'b0)
      xf(8'h42, 16'h0000, 24);
      `CHK(rerr, 1'b1)
      xf(8'h02, 16'h1234, 24);
      `CHK(werr, 1'b1)
      xf(8'h41, 16'h0000, 16);
      `CHK(cerr, 1'b1)
      rdc(16'h0200);
      wr(16'h0000);
      four = 1'b0;
      `CHK({werr, rerr, cerr}, 3'b000)
      xf(8'h42, 16'h0000, 24);
      `CHK(rerr, 1'b0)
      $display("test four wire done");
      give_verdict();
   end
endmodule
`default_nettype wire

// ---- verification/ccs_ctrl_props.sv ----
// Purpose: port level checks of the control block
// Assumes: all checks on clk, nrst synchronous active low
// Notes:   six-cycle windows cover the pin synchroniser lag
`timescale 1ns/1ps
`default_nettype none
module ccs_ctrl_props (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // link
   input wire logic cs_n,
   input wire logic dout_rdy_o,
   input wire logic dout_rdy_oe,
   // controls and flags
   input wire logic ref_enable,
   input wire logic internal_reference_level_select,
   input wire logic filter_reset,
   input wire logic conv_single,
   input wire logic conv_standby,
   input wire logic conv_power_down,
   input wire logic serial_write_error_flag,
   input wire logic serial_read_error_flag,
   input wire logic serial_clock_count_error_flag
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_idle_float: assert property (cs_n [*6] |-> !dout_rdy_oe)
      else $error("pin driven with select high");
   a_sel_drive: assert property (!cs_n [*6] |-> dout_rdy_oe)
      else $error("pin not driven with select low");
   a_ref_level: assert property (internal_reference_level_select
      |-> ref_enable)
      else $error("level select without reference");
   a_mode_excl: assert property ($onehot0({filter_reset, conv_single,
      conv_standby, conv_power_down}))
      else $error("two modes at once");
   a_pdown_entry: assert property ($rose(conv_power_down)
      |-> $past(conv_standby))
      else $error("power-down not from standby");
   a_reset_vals: assert property ($rose(nrst) |-> !ref_enable
      && !filter_reset && !conv_single && !conv_standby
      && !conv_power_down && dout_rdy_o)
      else $error("bad value after reset");
   a_flags_clear: assert property ($fell(serial_write_error_flag)
      || $fell(serial_read_error_flag)
      || $fell(serial_clock_count_error_flag)
      |-> !(serial_write_error_flag || serial_read_error_flag
      || serial_clock_count_error_flag))
      else $error("flags cleared apart");
   a_count_cs: assert property ($rose(serial_clock_count_error_flag)
      |-> $past(cs_n))
      else $error("count error before select rise");
   cover property ($rose(conv_power_down));
   cover property ($rose(filter_reset));
   cover property ($rose(serial_clock_count_error_flag));
endmodule
bind ccs_ctrl ccs_ctrl_props u_props (.clk(clk), .nrst(nrst),
   .cs_n(cs_n), .dout_rdy_o(dout_rdy_o), .dout_rdy_oe(dout_rdy_oe),
   .ref_enable(ref_enable),
   .internal_reference_level_select(internal_reference_level_select),
   .filter_reset(filter_reset), .conv_single(conv_single),
   .conv_standby(conv_standby), .conv_power_down(conv_power_down),
   .serial_write_error_flag(serial_write_error_flag),
   .serial_read_error_flag(serial_read_error_flag),
   .serial_clock_count_error_flag(serial_clock_count_error_flag));
`default_nettype wire

// ---- verification/ccs_host.sv ----
// Purpose: host side of the serial link, makes sclk only within frames
// Assumes: sclk idles high, data changed on falling, sampled on rising
// Notes:   returns at the last rising edge in 3-wire, at select rise 32 ns later in 4-wire, so pin timing can be measured
`timescale 1ns/1ps
`default_nettype none
module ccs_host (
   // link to device
   output logic      sclk,
   output logic      cs_n,
   output logic      din,
   input  wire logic dout
);
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din  = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic xfer(input logic [7:0] c, input logic [15:0] d,
                       input int n, input logic four,
                       output logic [15:0] r);
      logic [23:0] w;
      w = {c, d};
      r = 16'h0000;
      cs_n = 1'b0;
      #32;
      for (int i = 0; i < n; i++) begin
         sclk = 1'b0;
         din = w[23];
         w = w << 1;
         #32;
         if (i >= 8) r = {r[14:0], dout};
         sclk = 1'b1;
         if (i < n - 1) #32;
      end
      // released line must not keep its last level
      din = ~din;
      if (four) begin
         #32;
         cs_n = 1'b1;
      end
   endtask
endmodule
`default_nettype wire
